// >>> ddrz_ctrl_model.sv
// Controller-side model: free-running link clock, cke, odt, commands.
// Assumes the bench calls one task at a time from a single process.
module ddrz_ctrl_model (
  input  wire          clk,
  output logic         ck,
  output logic         cke,
  output logic         cs_n,
  output logic         ras_n,
  output logic         cas_n,
  output logic         we_n,
  output logic [2:0]   ba,
  output logic [15:0]  addr,
  output logic         odt
);
  timeunit 1ns;
  timeprecision 100ps;

  // Link clock runs on through power-down; phase drifts against clk
  initial begin
    ck = 1'b0;
    cke = 1'b0;
    odt = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    ba = 3'h0;
    addr = 16'h0000;
  end
  always #62.5 ck = ~ck;

  // Command held across its ck rise, then deselected with flipped lines
  task automatic issue(input logic [3:0] c, input logic [2:0] b,
                       input logic [15:0] a, input logic k);
    @(negedge ck);
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= c;
    ba <= b;
    addr <= a;
    cke <= k;
    @(posedge ck);
    @(posedge clk);
    cs_n <= 1'b1;
    {ras_n, cas_n, we_n} <= ~{ras_n, cas_n, we_n};
    ba <= ~ba;
    addr <= ~addr;
  endtask

  // Level pins, registered at the next ck rise
  task automatic pins(input logic k, input logic o);
    @(negedge ck);
    @(posedge clk);
    cke <= k;
    odt <= o;
    @(posedge ck);
    @(posedge clk);
  endtask
endmodule // ddrz_ctrl_model

// >>> ddrz_regs.vh
// Timing counts, field positions and command codes for the termination and
// calibration block. Included by every design file except the synchroniser; definitions only.
//
// Behaviour
// - Frozen DLL in precharge power-down: asynchronous termination
// - Asynchronous path ignores additive latency
// - Async timing referenced to sampled ODT level
// - Transition windows only when A12 freezes DLL
// - Entry window: WL-1 before CKE low, tCPDED after
// - Entry start excluded, end point included
// - Pending refresh extends entry window to tRFC
// - Turn-on inside window within combined bounds
// - Turn-off inside window within combined bounds
// - Exit window: WL-1 before CKE high, tXPDLL after
// - Overlapping entry/exit: either response throughout
// - Overlapping exit/entry: either response throughout
// - Long calibration runs engine, then transfers codes
// - First long calibration gets init period
// - Short calibration corrects within 64 clocks
// - No recalibration after self-refresh without command
// - Calibration current path off when done
// - Synchronous termination follows ODT after WL-2
`ifndef DDRZ_REGS_VH
`define DDRZ_REGS_VH

// Internal clock period, in picoseconds
`define DDRZ_CLK_PERIOD_PS 8000
// Asynchronous turn-on/off delay, in picoseconds
`define DDRZ_TAONPD_PS 8500
// Same delay in internal clock cycles, rounded up, at least one
`define DDRZ_TAONPD_CYC \
  ((`DDRZ_TAONPD_PS + `DDRZ_CLK_PERIOD_PS - 1) / `DDRZ_CLK_PERIOD_PS)

// Link-clock counts (in ck cycles)
`define DDRZ_TCPDED_NCK 8'h01
`define DDRZ_TXPDLL_NCK 8'h0A
`define DDRZ_TRFC_NCK   8'h40
`define DDRZ_ZQINIT_NCK 10'h200
`define DDRZ_ZQOPER_NCK 10'h100
`define DDRZ_ZQCS_NCK   10'h040
`define DDRZ_ZQCORR_NCK 10'h040

// Field positions
`define DDRZ_MR0_DLLPD_BIT 12
`define DDRZ_AP_BIT        10
`define DDRZ_MR0_BANK      3'h0

// Command codes {cs_n, ras_n, cas_n, we_n}
`define DDRZ_CMD_MRS 4'h0
`define DDRZ_CMD_REF 4'h1
`define DDRZ_CMD_PRE 4'h2
`define DDRZ_CMD_ACT 4'h3
`define DDRZ_CMD_ZQ  4'h6

// Synchronous ODT history depth and impedance code width
`define DDRZ_PIPE_LEN  32
`define DDRZ_CODE_W    6
`define DDRZ_CODE_MID  6'h20

`endif

// >>> ddrz_sync.v
// Three-stage synchroniser for pins arriving from outside the clk domain.
// Assumes each bit is a slow level relative to clk; output updates only
// when the second and third stages agree.
module ddrz_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         reset_n,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);

  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  integer     i;

  // Chain; first stage feeds only the second
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
      s3_reg <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Accept a bit only once stages two and three agree
      for (i = 0; i < W; i = i + 1) begin
        if (s2_reg[i] == s3_reg[i]) begin
          dout[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule // ddrz_sync

// >>> ddrz_top.v
// Termination timing and impedance calibration inside the memory device.
// Assumes ck, cke, command pins, odt and the comparator are asynchronous to
// clk and slow enough to be oversampled; wl_cfg is static during operation.
`include "ddrz_regs.vh"
module ddrz_top (
  input  wire                    clk,
  input  wire                    reset_n,
  input  wire                    ck,
  input  wire                    cke,
  input  wire                    cs_n,
  input  wire                    ras_n,
  input  wire                    cas_n,
  input  wire                    we_n,
  input  wire [2:0]              ba,
  input  wire [15:0]             addr,
  input  wire                    odt,
  input  wire                    zq_cmp,
  input  wire [4:0]              wl_cfg,
  output reg                     rtt_on,
  output reg                     odt_async,
  output reg                     pd_window,
  output reg                     pd_active,
  output reg                     self_ref,
  output wire                    zq_busy,
  output wire                    zq_cur_en,
  output wire                    zq_done,
  output wire [`DDRZ_CODE_W-1:0] ron_code,
  output wire [`DDRZ_CODE_W-1:0] rtt_code
);

  localparam ADLY = `DDRZ_TAONPD_CYC;
  localparam PL   = `DDRZ_PIPE_LEN;

  // Synchronised pin levels
  wire [12:0] pin_s;
  wire        s_ck;
  wire        s_cke;
  wire [3:0]  s_cmd;
  wire [2:0]  s_ba;
  wire        s_a12;
  wire        s_a10;
  wire        s_odt;
  wire        s_cmp;

  reg          ck_prev_reg;
  reg          cke_q_reg;
  reg          dll_frz_reg;
  reg  [7:0]   bank_open_reg;
  reg  [7:0]   rfc_cnt_reg;
  reg  [7:0]   ent_cnt_reg;
  reg  [7:0]   ext_cnt_reg;
  reg  [PL-1:0] odt_pipe_reg;
  reg  [ADLY-1:0] apd_pipe_reg;
  reg          rtt_sync_reg;
  reg          zq_start_reg;
  reg          zq_long_reg;
  reg  [7:0]   ent_next;
  reg          async_next;

  wire         ck_rise;
  wire         cke_fall;
  wire         cke_rise;
  wire         cmd_mrs;
  wire         cmd_ref;
  wire         cmd_pre;
  wire         cmd_act;
  wire         cmd_zq;
  wire         ppd;

  ddrz_sync #(
    .W (13)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .din     ({ck, cke, cs_n, ras_n, cas_n, we_n, ba,
               addr[`DDRZ_MR0_DLLPD_BIT], addr[`DDRZ_AP_BIT], odt, zq_cmp}),
    .dout    (pin_s)
  );

  assign s_ck  = pin_s[12];
  assign s_cke = pin_s[11];
  assign s_cmd = pin_s[10:7];
  assign s_ba  = pin_s[6:4];
  assign s_a12 = pin_s[3];
  assign s_a10 = pin_s[2];
  assign s_odt = pin_s[1];
  assign s_cmp = pin_s[0];

  // Tap of the ODT history after n link edges; WL-2 never below one
  function tap;
    input [PL-1:0] hist;
    input [4:0]    wl;
    reg   [4:0]    n;
    begin
      n = (wl > 5'h02) ? (wl - 5'h02) : 5'h01;
      tap = hist[n];
    end
  endfunction

  // Link edge and command decode, all on registered ck rising edges
  assign ck_rise  = s_ck & ~ck_prev_reg;
  assign cke_fall = ck_rise & cke_q_reg & ~s_cke;
  assign cke_rise = ck_rise & ~cke_q_reg & s_cke;
  assign cmd_mrs  = ck_rise & cke_q_reg & (s_cmd == `DDRZ_CMD_MRS);
  assign cmd_ref  = ck_rise & (s_cmd == `DDRZ_CMD_REF);
  assign cmd_pre  = ck_rise & cke_q_reg & (s_cmd == `DDRZ_CMD_PRE);
  assign cmd_act  = ck_rise & cke_q_reg & (s_cmd == `DDRZ_CMD_ACT);
  assign cmd_zq   = ck_rise & cke_q_reg & (s_cmd == `DDRZ_CMD_ZQ);

  // Precharge power-down: CKE low, no bank open, not in self refresh
  assign ppd = pd_active & (bank_open_reg == 8'h00);

  // Edge history and CKE registration
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ck_prev_reg <= 1'b0;
      cke_q_reg   <= 1'b0;
    end else begin
      ck_prev_reg <= s_ck;
      if (ck_rise) begin
        cke_q_reg <= s_cke;
      end
    end
  end

  // Mode bit and bank bookkeeping; freeze chosen when the bit is zero
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dll_frz_reg   <= 1'b0;
      bank_open_reg <= 8'h00;
    end else begin
      if (cmd_mrs && s_ba == `DDRZ_MR0_BANK) begin
        dll_frz_reg <= ~s_a12;
      end
      if (cmd_act) begin
        bank_open_reg[s_ba] <= 1'b1;
      end else if (cmd_pre && s_a10) begin
        bank_open_reg <= 8'h00;
      end else if (cmd_pre) begin
        bank_open_reg[s_ba] <= 1'b0;
      end
    end
  end

  // Power-down, self refresh and refresh-in-progress tracking
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pd_active   <= 1'b0;
      self_ref    <= 1'b0;
      rfc_cnt_reg <= 8'h00;
    end else begin
      if (cmd_ref && cke_q_reg && s_cke) begin
        rfc_cnt_reg <= `DDRZ_TRFC_NCK;
      end else if (ck_rise && rfc_cnt_reg != 8'h00) begin
        rfc_cnt_reg <= rfc_cnt_reg - 8'h01;
      end
      if (cke_fall && s_cmd == `DDRZ_CMD_REF) begin
        self_ref <= 1'b1;
      end else if (cke_fall) begin
        pd_active <= 1'b1;
      end else if (cke_rise) begin
        // Self-refresh exit leaves codes untouched until a command
        self_ref  <= 1'b0;
        pd_active <= 1'b0;
      end
    end
  end

  // Entry window length: tCPDED, or the refresh end if later
  always @* begin
    ent_next = `DDRZ_TCPDED_NCK;
    if (rfc_cnt_reg > `DDRZ_TCPDED_NCK) begin
      ent_next = rfc_cnt_reg;
    end
  end

  // Transition windows; exist only with the DLL frozen
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ent_cnt_reg <= 8'h00;
      ext_cnt_reg <= 8'h00;
    end else begin
      if (cke_fall && dll_frz_reg && bank_open_reg == 8'h00) begin
        ent_cnt_reg <= ent_next;
      end else if (ck_rise && ent_cnt_reg != 8'h00) begin
        // Last counted cycle still inside: end point included
        ent_cnt_reg <= ent_cnt_reg - 8'h01;
      end
      if (cke_rise && dll_frz_reg && ppd) begin
        ext_cnt_reg <= `DDRZ_TXPDLL_NCK;
      end else if (ck_rise && ext_cnt_reg != 8'h00) begin
        ext_cnt_reg <= ext_cnt_reg - 8'h01;
      end
    end
  end

  // Mode choice. Inside any window either response is legal, so the
  // asynchronous one is taken from CKE registration onward; changes in the
  // WL-1 clocks before it are still in the synchronous pipe and get
  // re-timed by the async path, which lands within the combined bounds.
  always @* begin
    async_next = dll_frz_reg & (ppd | (ent_cnt_reg != 8'h00)
                 | (ext_cnt_reg != 8'h00));
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      odt_async <= 1'b0;
      pd_window <= 1'b0;
    end else begin
      odt_async <= async_next;
      pd_window <= dll_frz_reg & ((ent_cnt_reg != 8'h00)
                   | (ext_cnt_reg != 8'h00));
    end
  end

  // Synchronous path: ODT history per link edge, WL carries the AL
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      odt_pipe_reg <= {PL{1'b0}};
      rtt_sync_reg <= 1'b0;
    end else if (ck_rise) begin
      odt_pipe_reg <= {odt_pipe_reg[PL-2:0], s_odt};
      rtt_sync_reg <= tap({odt_pipe_reg[PL-2:0], s_odt}, wl_cfg);
    end
  end

  // Asynchronous path: sampled ODT level plus fixed delay, no AL term
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      apd_pipe_reg <= {ADLY{1'b0}};
    end else if (ADLY > 1) begin
      apd_pipe_reg <= {apd_pipe_reg[ADLY-2:0], s_odt};
    end else begin
      apd_pipe_reg <= {ADLY{s_odt}};
    end
  end

  // Termination output; the mode switch happens only in a window, where
  // both timings are permitted for rising and falling changes
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rtt_on <= 1'b0;
    end else if (async_next) begin
      rtt_on <= apd_pipe_reg[ADLY-1];
    end else begin
      rtt_on <= rtt_sync_reg;
    end
  end

  // Calibration command capture; A10 picks long over short
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      zq_start_reg <= 1'b0;
      zq_long_reg  <= 1'b0;
    end else begin
      zq_start_reg <= cmd_zq & ~self_ref;
      if (cmd_zq) begin
        zq_long_reg <= s_a10;
      end
    end
  end

  ddrz_zqcal u_zqcal (
    .clk      (clk),
    .reset_n  (reset_n),
    .tick     (ck_rise),
    .start    (zq_start_reg),
    .long_cal (zq_long_reg),
    .cmp_up   (s_cmp),
    .busy     (zq_busy),
    .cur_en   (zq_cur_en),
    .done     (zq_done),
    .ron_code (ron_code),
    .rtt_code (rtt_code)
  );

endmodule // ddrz_top

// >>> ddrz_top_assertions.sv
// Port-level checks for the termination and calibration block.
// Assumes one clk domain with the asynchronous active-low reset_n.
`include "ddrz_regs.vh"
module ddrz_top_checker (
  input wire                    clk,
  input wire                    reset_n,
  input wire                    odt,
  input wire                    rtt_on,
  input wire                    odt_async,
  input wire                    pd_window,
  input wire                    pd_active,
  input wire                    zq_busy,
  input wire                    zq_cur_en,
  input wire                    zq_done,
  input wire [`DDRZ_CODE_W-1:0] ron_code,
  input wire [`DDRZ_CODE_W-1:0] rtt_code
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Calibration engine and its current path
  a_cur_tracks_busy: assert property (zq_cur_en == zq_busy)
    else $error("calibration current differs from busy");
  a_done_at_end: assert property (zq_done |-> $past(zq_busy) && !zq_busy)
    else $error("done without a finished calibration");
  a_codes_on_done: assert property (!zq_done |-> $stable(ron_code) && $stable(rtt_code))
    else $error("codes moved outside the transfer pulse");
  a_done_one_clk: assert property (zq_done |=> !zq_done)
    else $error("done longer than one cycle");

  // Termination timing mode
  a_window_async: assert property (pd_window |-> odt_async)
    else $error("window without the bounded response");
  a_async_in_pd: assert property (odt_async |-> pd_active || $past(pd_active) || pd_window || $past(pd_window))
    else $error("async timing outside power-down");
  a_async_follow: assert property ((odt_async && $stable(odt))[*8] |=> rtt_on == $past(odt))
    else $error("async termination not following odt");
  a_sync_no_early: assert property (!odt_async && !rtt_on && $rose(odt) |=> (!rtt_on)[*8])
    else $error("sync termination too early");
  a_sync_on_bound: assert property (!odt_async && !rtt_on && $rose(odt) |-> ##[1:500] rtt_on)
    else $error("sync termination never on");

  // Main scenarios reached
  cover property (zq_done);
  cover property ($rose(pd_window));
  cover property ($rose(odt_async) ##[1:300] $rose(rtt_on));
endmodule // ddrz_top_checker

bind ddrz_top ddrz_top_checker u_chk (.*);

// >>> ddrz_top_tb_top.sv
// Self-checking bench for the termination and calibration block.
// Assumes the controller model owns the link clock and pin timing.
`include "ddrz_regs.vh"
module ddrz_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                    clk = 1'b0;
  logic                    reset_n = 1'b0;
  logic                    zq_cmp = 1'b0;
  wire                     ck, cke, cs_n, ras_n, cas_n, we_n, odt;
  wire  [2:0]              ba;
  wire  [15:0]             addr;
  wire                     rtt_on, odt_async, pd_window, pd_active;
  wire                     self_ref, zq_busy, zq_cur_en, zq_done;
  wire  [`DDRZ_CODE_W-1:0] ron_code, rtt_code;
  wire  [5:0]              flags;
  int                      failures = 0;
  int                      compares = 0;
  int                      cycles = 0;

  // Status flags packed for one compare
  assign flags = {rtt_on, odt_async, pd_window, pd_active, self_ref, zq_busy};
  always #4 clk = ~clk;

  ddrz_ctrl_model mdl (.clk, .ck, .cke, .cs_n, .ras_n, .cas_n, .we_n,
    .ba, .addr, .odt);
  ddrz_top dut (.clk, .reset_n, .ck, .cke, .cs_n, .ras_n, .cas_n, .we_n,
    .ba, .addr, .odt, .zq_cmp, .wl_cfg(5'h05), .rtt_on, .odt_async,
    .pd_window, .pd_active, .self_ref, .zq_busy, .zq_cur_en, .zq_done,
    .ron_code, .rtt_code);

  // Hang guard, about two and a half times the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      $display("wrong value at %0t: run did not finish", $time);
      summarize();
    end
  end

  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Settle ten clk past the n-th following ck rise
  task automatic after_ck(input int n);
    repeat (n) @(posedge ck);
    repeat (10) @(posedge clk);
  endtask

  task automatic t_sync_odt();
    mdl.pins(1'b1, 1'b1);
    after_ck(2);
    chk(flags, 6'h00);
    after_ck(1);
    chk(flags, 6'h20);
    mdl.pins(1'b1, 1'b0);
    after_ck(2);
    chk(flags, 6'h20);
    after_ck(1);
    chk(flags, 6'h00);
  endtask

  task automatic t_pd_dll_on();
    mdl.issue(`DDRZ_CMD_MRS, 3'h0, 16'h1000, 1'b1);
    mdl.pins(1'b0, 1'b0);
    after_ck(3);
    chk(flags, 6'h04);
    mdl.pins(1'b1, 1'b0);
    after_ck(1);
    chk(flags, 6'h00);
  endtask

  task automatic t_pd_frozen();
    mdl.issue(`DDRZ_CMD_MRS, 3'h0, 16'h0000, 1'b1);
    mdl.pins(1'b0, 1'b0);
    after_ck(0);
    chk(flags, 6'h1C);
    after_ck(2);
    chk(flags, 6'h14);
    mdl.pins(1'b0, 1'b1);
    repeat (12) @(posedge clk);
    chk(flags, 6'h34);
    mdl.pins(1'b0, 1'b0);
    repeat (12) @(posedge clk);
    chk(flags, 6'h14);
    mdl.pins(1'b1, 1'b0);
    after_ck(8);
    chk(flags, 6'h18);
    after_ck(4);
    chk(flags, 6'h00);
  endtask

  task automatic t_pd_refresh();
    mdl.issue(`DDRZ_CMD_REF, 3'h0, 16'h0000, 1'b1);
    mdl.pins(1'b0, 1'b0);
    after_ck(40);
    chk(flags, 6'h1C);
    after_ck(30);
    chk(flags, 6'h14);
    mdl.pins(1'b1, 1'b0);
    after_ck(12);
    chk(flags, 6'h00);
  endtask

  task automatic t_self_refresh();
    mdl.issue(`DDRZ_CMD_REF, 3'h0, 16'h0000, 1'b0);
    after_ck(2);
    chk(flags, 6'h02);
    mdl.issue(`DDRZ_CMD_ZQ, 3'h0, 16'h0400, 1'b0);
    after_ck(3);
    chk(flags, 6'h02);
    mdl.pins(1'b1, 1'b0);
    after_ck(20);
    chk(flags, 6'h00);
    chk(ron_code, `DDRZ_CODE_MID);
    chk(rtt_code, `DDRZ_CODE_MID);
  endtask

  // One calibration; ron_code holds until the end, then both codes move with the comparator
  task automatic zq_run(input logic [15:0] a, input int n, input logic up);
    logic [5:0] ron_old;
    logic [5:0] rtt_old;
    @(posedge clk);
    zq_cmp <= up;
    ron_old = ron_code;
    rtt_old = rtt_code;
    mdl.issue(`DDRZ_CMD_ZQ, 3'h0, a, 1'b1);
    after_ck(n - 1);
    chk(flags, 6'h01);
    chk(ron_code, ron_old);
    after_ck(2);
    chk(flags, 6'h00);
    chk({4'h0, up ? ron_code > ron_old : ron_code < ron_old,
         up ? rtt_code > rtt_old : rtt_code < rtt_old}, 6'h03);
  endtask

  task automatic t_zq();
    mdl.issue(`DDRZ_CMD_PRE, 3'h0, 16'h0400, 1'b1);
    after_ck(4);
    zq_run(16'h0400, 512, 1'b1);
    zq_run(16'h0400, 256, 1'b0);
    zq_run(16'h0000, 64, 1'b1);
  endtask

  task automatic summarize();
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence: reset, then each scenario in turn
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk(flags, 6'h00);
    chk(ron_code, `DDRZ_CODE_MID);
    t_sync_odt();
    t_pd_dll_on();
    t_pd_frozen();
    t_pd_refresh();
    t_self_refresh();
    t_zq();
    summarize();
  end
endmodule // ddrz_top_tb_top

// >>> ddrz_zqcal.v
// Impedance calibration engine: runs long or short calibration against
// the comparator, then transfers driver and termination codes at once.
// Assumes tick marks one link-clock rising edge in the clk domain.
`include "ddrz_regs.vh"
module ddrz_zqcal (
  input  wire                    clk,
  input  wire                    reset_n,
  input  wire                    tick,
  input  wire                    start,
  input  wire                    long_cal,
  input  wire                    cmp_up,
  output reg                     busy,
  output reg                     cur_en,
  output reg                     done,
  output reg  [`DDRZ_CODE_W-1:0] ron_code,
  output reg  [`DDRZ_CODE_W-1:0] rtt_code
);

  reg [9:0]              cnt_reg;
  reg [9:0]              half_reg;
  reg [9:0]              steps_reg;
  reg                    first_reg;
  reg                    long_reg;
  reg [`DDRZ_CODE_W-1:0] ron_work_reg;
  reg [`DDRZ_CODE_W-1:0] rtt_work_reg;

  // Saturating one-step move toward the comparator's verdict
  function [`DDRZ_CODE_W-1:0] step;
    input [`DDRZ_CODE_W-1:0] code;
    input                    up;
    begin
      if (up && code != {`DDRZ_CODE_W{1'b1}})
        step = code + 1'b1;
      else if (!up && code != {`DDRZ_CODE_W{1'b0}})
        step = code - 1'b1;
      else
        step = code;
    end
  endfunction

  // Sequencer: period by command kind, driver half then termination half
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy         <= 1'b0;
      cur_en       <= 1'b0;
      done         <= 1'b0;
      first_reg    <= 1'b1;
      long_reg     <= 1'b0;
      cnt_reg      <= 10'h000;
      half_reg     <= 10'h000;
      steps_reg    <= 10'h000;
      ron_work_reg <= `DDRZ_CODE_MID;
      rtt_work_reg <= `DDRZ_CODE_MID;
      ron_code     <= `DDRZ_CODE_MID;
      rtt_code     <= `DDRZ_CODE_MID;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy      <= 1'b1;
        cur_en    <= 1'b1;
        steps_reg <= 10'h000;
        long_reg  <= long_cal;
        if (long_cal && first_reg) begin
          cnt_reg  <= `DDRZ_ZQINIT_NCK;
          half_reg <= `DDRZ_ZQINIT_NCK >> 1;
        end else if (long_cal) begin
          cnt_reg  <= `DDRZ_ZQOPER_NCK;
          half_reg <= `DDRZ_ZQOPER_NCK >> 1;
        end else begin
          cnt_reg  <= `DDRZ_ZQCS_NCK;
          half_reg <= `DDRZ_ZQCS_NCK >> 1;
        end
        if (long_cal) begin
          first_reg <= 1'b0;
        end
      end else if (busy && tick) begin
        cnt_reg   <= cnt_reg - 10'h001;
        steps_reg <= steps_reg + 10'h001;
        // Short calibration settles inside the correction budget; long
        // ones trim through both halves so termination is reached too
        if (long_reg || steps_reg < `DDRZ_ZQCORR_NCK) begin
          if (cnt_reg > half_reg)
            ron_work_reg <= step(ron_work_reg, cmp_up);
          else
            rtt_work_reg <= step(rtt_work_reg, cmp_up);
        end
        if (cnt_reg == 10'h001) begin
          // Transfer both codes together so the I/O never mixes sets
          ron_code <= ron_work_reg;
          rtt_code <= rtt_work_reg;
          busy     <= 1'b0;
          cur_en   <= 1'b0;
          done     <= 1'b1;
        end
      end
    end
  end

endmodule // ddrz_zqcal
